// ==== common/wdt_resp_pkg.sv ====
// constants and types for the timeout response controller
package wdt_resp_pkg;

	////////////////////////////////////////////////////////////////
	// clock and times
	localparam int unsigned CLK_HZ         = 10_000_000;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned COLD_OFF_MS    = 4000;
	localparam int unsigned CYCLE_OFF_MS   = 3000;
	localparam int unsigned HW_RESET_MS    = 1;
	localparam int unsigned COLD_OFF_CYC   = COLD_OFF_MS * CYC_PER_MS;
	localparam int unsigned CYCLE_OFF_CYC  = CYCLE_OFF_MS * CYC_PER_MS;
	localparam int unsigned HW_RESET_CYC   = HW_RESET_MS * CYC_PER_MS;
	localparam int unsigned TIMER_W        = 26;

	////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam int unsigned ADDR_W         = 12;
	localparam logic [11:0] IDX_JUMPER     = 12'h1D2;
	localparam logic [11:0] IDX_RESPONSE   = 12'h1D3;
	localparam logic [11:0] IDX_IRQ_STATUS = 12'h1D4;
	localparam logic [11:0] IDX_IRQ_MASK   = 12'h1D5;
	localparam logic [11:0] IDX_CONFIG     = 12'h1D6;

	////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned JMP_USER_BIT   = 1;
	localparam int unsigned JMP_SETTINGS_BIT = 0;
	localparam int unsigned RSP_PIN_BIT    = 7;
	localparam int unsigned RSP_WDT_LSB    = 4;
	localparam int unsigned RSP_MON_BIT    = 3;
	localparam int unsigned RSP_HWM_LSB    = 0;
	localparam int unsigned IRQ_TIMEOUT_BIT = 0;
	localparam int unsigned IRQ_MONITOR_BIT = 1;
	localparam int unsigned IRQ_DONE_BIT   = 2;
	localparam int unsigned IRQ_N          = 3;
	localparam int unsigned CFG_CODE11_BIT = 0;

	////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [1:0] WDT_SEL_RESET   = 2'h0;
	localparam logic [1:0] MON_SEL_RESET   = 2'h0;
	localparam logic [2:0] IRQ_MASK_RESET  = 3'h0;
	localparam logic       CODE11_RESET    = 1'b0;

	////////////////////////////////////////////////////////////////
	// response codes
	localparam logic [1:0] CODE_NONE       = 2'h0;
	localparam logic [1:0] CODE_01         = 2'h1;
	localparam logic [1:0] CODE_10         = 2'h2;
	localparam logic [1:0] CODE_11         = 2'h3;

	// ordered by severity: a larger code wins
	typedef enum logic [2:0] {
		ACT_NONE     = 3'h0,
		ACT_HW_RESET = 3'h1,
		ACT_CYCLE    = 3'h2,
		ACT_COLD     = 3'h3,
		ACT_OFF      = 3'h4
	} action_t;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'h0,
		ST_HOLD     = 2'h1,
		ST_OFF_WAIT = 2'h3,
		ST_SHUTDOWN = 2'h2
	} seq_state_t;

	typedef enum logic [2:0] {
		SEL_JUMPER,
		SEL_RESPONSE,
		SEL_IRQ_STATUS,
		SEL_IRQ_MASK,
		SEL_CONFIG,
		SEL_NONE
	} reg_sel_t;

endpackage

// ==== rtl/interval_timer.sv ====
// down-counter that flags the end of a loaded interval
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
	parameter int unsigned WIDTH = 26
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_val,
	output var  logic             expired
);

	logic [WIDTH-1:0] count_q;

	if (WIDTH < 2) begin : g_chk
		$error("interval_timer needs at least two bits");
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_val;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	// one-cycle pulse on the last count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			expired <= 1'b0;
		end else begin
			expired <= !load && (count_q == WIDTH'(1));
		end
	end

endmodule

`default_nettype wire

// ==== rtl/timeout_response.sv ====
// jumper status and watchdog/monitor response controller, APB slave
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - jumper bits seven to two read zero
// - bit one shows user jumper installed
// - bit zero shows settings-reset jumper installed
// - bit seven reads timeout pin inverted
// - response bit six reserved, reads zero
// - either pin asserting starts its selected response; the sequencer acts only in idle, and of two at once on the more severe
// - timeout codes: none, cold, 3 s cycle
// - cold reset keeps power off 4 s
// - offer hardware reset and full shutdown
// - monitor codes: none, thermal, cold, off
module timeout_response #(
	parameter int unsigned TIMER_W       = wdt_resp_pkg::TIMER_W,
	parameter int unsigned COLD_OFF_CYC  = wdt_resp_pkg::COLD_OFF_CYC,
	parameter int unsigned CYCLE_OFF_CYC = wdt_resp_pkg::CYCLE_OFF_CYC,
	parameter int unsigned HW_RESET_CYC  = wdt_resp_pkg::HW_RESET_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        user_jumper_installed,
	input  wire logic        settings_reset_jumper_installed,
	input  wire logic        external_timeout_pin,
	input  wire logic        external_monitor_alert_pin_n,
	output var  logic        thermal_alarm_out_n,
	output var  logic        board_power_en,
	output var  logic        system_reset_n,
	output var  logic        irq
);

	////////////////////////////////////////////////////////////////
	// elaboration checks

	if (COLD_OFF_CYC < 1 || CYCLE_OFF_CYC < 1 || HW_RESET_CYC < 1 || COLD_OFF_CYC >= 2 ** TIMER_W ||
		CYCLE_OFF_CYC >= 2 ** TIMER_W || HW_RESET_CYC >= 2 ** TIMER_W) begin : g_chk_cnt
		$error("a cycle count does not fit the timer");
	end

	////////////////////////////////////////////////////////////////
	// functions

	function automatic wdt_resp_pkg::reg_sel_t decode(input logic [11:0] addr);
		logic [11:0] idx;
		idx = {2'h0, addr[11:2]};
		if (addr[1:0] != 2'h0) begin
			return wdt_resp_pkg::SEL_NONE;
		end
		unique case (idx)
			wdt_resp_pkg::IDX_JUMPER:     return wdt_resp_pkg::SEL_JUMPER;
			wdt_resp_pkg::IDX_RESPONSE:   return wdt_resp_pkg::SEL_RESPONSE;
			wdt_resp_pkg::IDX_IRQ_STATUS: return wdt_resp_pkg::SEL_IRQ_STATUS;
			wdt_resp_pkg::IDX_IRQ_MASK:   return wdt_resp_pkg::SEL_IRQ_MASK;
			wdt_resp_pkg::IDX_CONFIG:     return wdt_resp_pkg::SEL_CONFIG;
			default:                      return wdt_resp_pkg::SEL_NONE;
		endcase
	endfunction

	// timeout codes; code 11 follows the config bit
	function automatic wdt_resp_pkg::action_t wdt_action(input logic [1:0] code, input logic alt);
		unique case (code)
			wdt_resp_pkg::CODE_NONE: return wdt_resp_pkg::ACT_NONE;
			wdt_resp_pkg::CODE_01:   return wdt_resp_pkg::ACT_COLD;
			wdt_resp_pkg::CODE_10:   return wdt_resp_pkg::ACT_CYCLE;
			default:                 return alt ? wdt_resp_pkg::ACT_OFF : wdt_resp_pkg::ACT_HW_RESET;
		endcase
	endfunction

	// thermal alarm is handled apart from the sequencer
	function automatic wdt_resp_pkg::action_t mon_action(input logic [1:0] code);
		unique case (code)
			wdt_resp_pkg::CODE_10: return wdt_resp_pkg::ACT_COLD;
			wdt_resp_pkg::CODE_11: return wdt_resp_pkg::ACT_OFF;
			default:               return wdt_resp_pkg::ACT_NONE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// declarations

	logic                    user_jmp_q;
	logic                    settings_jmp_q;
	logic                    wdt_low_q;
	logic                    mon_low_q;
	logic                    wdt_edge;
	logic                    mon_edge;
	logic [1:0]              wdt_sel_q;
	logic [1:0]              mon_sel_q;
	logic                    code11_off_q;
	logic [wdt_resp_pkg::IRQ_N-1:0] irq_status_q;
	logic [wdt_resp_pkg::IRQ_N-1:0] irq_status_d;
	logic [wdt_resp_pkg::IRQ_N-1:0] irq_mask_q;
	logic [wdt_resp_pkg::IRQ_N-1:0] irq_event;
	logic                    setup;
	logic                    wr_commit;
	wdt_resp_pkg::reg_sel_t  sel;
	logic [7:0]              jumper_val;
	logic [7:0]              response_val;
	logic [31:0]             rd_val;
	wdt_resp_pkg::action_t   act_wdt;
	wdt_resp_pkg::action_t   act_mon;
	wdt_resp_pkg::action_t   act_start;
	wdt_resp_pkg::seq_state_t state_q;
	wdt_resp_pkg::seq_state_t state_d;
	logic                    timer_load;
	logic [TIMER_W-1:0]      timer_val;
	logic                    timer_expired;
	logic                    seq_done;

	////////////////////////////////////////////////////////////////
	// pin sampling

	// both timeout pins are asserted low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_jmp_q     <= 1'b0;
			settings_jmp_q <= 1'b0;
			wdt_low_q      <= 1'b0;
			mon_low_q      <= 1'b0;
		end else begin
			user_jmp_q     <= user_jumper_installed;
			settings_jmp_q <= settings_reset_jumper_installed;
			wdt_low_q      <= !external_timeout_pin;
			mon_low_q      <= !external_monitor_alert_pin_n;
		end
	end

	// act on the assertion edge only, so a pin held low fires once
	assign wdt_edge = !external_timeout_pin && !wdt_low_q;
	assign mon_edge = !external_monitor_alert_pin_n && !mon_low_q;

	////////////////////////////////////////////////////////////////
	// register read values

	always_comb begin
		jumper_val = 8'h00;
		jumper_val[wdt_resp_pkg::JMP_USER_BIT]     = user_jmp_q;
		jumper_val[wdt_resp_pkg::JMP_SETTINGS_BIT] = settings_jmp_q;
	end

	always_comb begin
		response_val = 8'h00;
		response_val[wdt_resp_pkg::RSP_PIN_BIT] = wdt_low_q;
		response_val[wdt_resp_pkg::RSP_WDT_LSB +: 2] = wdt_sel_q;
		response_val[wdt_resp_pkg::RSP_MON_BIT] = mon_low_q;
		response_val[wdt_resp_pkg::RSP_HWM_LSB +: 2] = mon_sel_q;
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (sel)
			wdt_resp_pkg::SEL_JUMPER:     rd_val[7:0] = jumper_val;
			wdt_resp_pkg::SEL_RESPONSE:   rd_val[7:0] = response_val;
			wdt_resp_pkg::SEL_IRQ_STATUS: rd_val[wdt_resp_pkg::IRQ_N-1:0] = irq_status_q;
			wdt_resp_pkg::SEL_IRQ_MASK:   rd_val[wdt_resp_pkg::IRQ_N-1:0] = irq_mask_q;
			wdt_resp_pkg::SEL_CONFIG:     rd_val[wdt_resp_pkg::CFG_CODE11_BIT] = code11_off_q;
			wdt_resp_pkg::SEL_NONE:       rd_val = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// apb slave: one wait-free access cycle after setup

	assign sel       = decode(paddr);
	assign setup     = psel && !penable;
	assign wr_commit = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// read data is captured at setup and held through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_val;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && (sel == wdt_resp_pkg::SEL_NONE);
		end
	end

	////////////////////////////////////////////////////////////////
	// writable fields

	// jumper bits and pin states ignore writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_sel_q <= wdt_resp_pkg::WDT_SEL_RESET;
			mon_sel_q <= wdt_resp_pkg::MON_SEL_RESET;
		end else if (wr_commit && sel == wdt_resp_pkg::SEL_RESPONSE) begin
			wdt_sel_q <= pwdata[wdt_resp_pkg::RSP_WDT_LSB +: 2];
			mon_sel_q <= pwdata[wdt_resp_pkg::RSP_HWM_LSB +: 2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code11_off_q <= wdt_resp_pkg::CODE11_RESET;
		end else if (wr_commit && sel == wdt_resp_pkg::SEL_CONFIG) begin
			code11_off_q <= pwdata[wdt_resp_pkg::CFG_CODE11_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_q <= wdt_resp_pkg::IRQ_MASK_RESET;
		end else if (wr_commit && sel == wdt_resp_pkg::SEL_IRQ_MASK) begin
			irq_mask_q <= pwdata[wdt_resp_pkg::IRQ_N-1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, a new event wins

	always_comb begin
		irq_event = '0;
		irq_event[wdt_resp_pkg::IRQ_TIMEOUT_BIT] = wdt_edge;
		irq_event[wdt_resp_pkg::IRQ_MONITOR_BIT] = mon_edge;
		irq_event[wdt_resp_pkg::IRQ_DONE_BIT]    = seq_done;
	end

	always_comb begin
		irq_status_d = irq_status_q;
		if (wr_commit && sel == wdt_resp_pkg::SEL_IRQ_STATUS) begin
			irq_status_d = irq_status_q & ~pwdata[wdt_resp_pkg::IRQ_N-1:0];
		end
		irq_status_d = irq_status_d | irq_event;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_q <= '0;
			irq          <= 1'b0;
		end else begin
			irq_status_q <= irq_status_d;
			irq          <= |(irq_status_d & irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////
	// thermal alarm follows the alert pin while selected

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermal_alarm_out_n <= 1'b1;
		end else begin
			thermal_alarm_out_n <= !(!external_monitor_alert_pin_n && mon_sel_q == wdt_resp_pkg::CODE_01);
		end
	end

	////////////////////////////////////////////////////////////////
	// response sequencer

	assign act_wdt = wdt_edge ? wdt_action(wdt_sel_q, code11_off_q) : wdt_resp_pkg::ACT_NONE;
	assign act_mon = mon_edge ? mon_action(mon_sel_q) : wdt_resp_pkg::ACT_NONE;

	// both at once: the more severe action is taken
	assign act_start = (act_mon > act_wdt) ? act_mon : act_wdt;

	// events while a sequence runs are flagged but not acted on
	always_comb begin
		state_d    = state_q;
		timer_load = 1'b0;
		timer_val  = '0;
		seq_done   = 1'b0;
		unique case (state_q)
			wdt_resp_pkg::ST_IDLE: begin
				unique case (act_start)
					wdt_resp_pkg::ACT_HW_RESET: begin
						state_d    = wdt_resp_pkg::ST_HOLD;
						timer_load = 1'b1;
						timer_val  = TIMER_W'(HW_RESET_CYC);
					end
					wdt_resp_pkg::ACT_COLD: begin
						state_d    = wdt_resp_pkg::ST_OFF_WAIT;
						timer_load = 1'b1;
						timer_val  = TIMER_W'(COLD_OFF_CYC);
					end
					wdt_resp_pkg::ACT_CYCLE: begin
						state_d    = wdt_resp_pkg::ST_OFF_WAIT;
						timer_load = 1'b1;
						timer_val  = TIMER_W'(CYCLE_OFF_CYC);
					end
					wdt_resp_pkg::ACT_OFF: begin
						state_d = wdt_resp_pkg::ST_SHUTDOWN;
					end
					default: begin
						state_d = wdt_resp_pkg::ST_IDLE;
					end
				endcase
			end
			wdt_resp_pkg::ST_OFF_WAIT: begin
				if (timer_expired) begin
					state_d    = wdt_resp_pkg::ST_HOLD;
					timer_load = 1'b1;
					timer_val  = TIMER_W'(HW_RESET_CYC);
				end
			end
			wdt_resp_pkg::ST_HOLD: begin
				if (timer_expired) begin
					state_d  = wdt_resp_pkg::ST_IDLE;
					seq_done = 1'b1;
				end
			end
			wdt_resp_pkg::ST_SHUTDOWN: begin
				state_d = wdt_resp_pkg::ST_SHUTDOWN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= wdt_resp_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	interval_timer #(
		.WIDTH (TIMER_W)
	) u_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.load     (timer_load),
		.load_val (timer_val),
		.expired  (timer_expired)
	);

	////////////////////////////////////////////////////////////////
	// board controls follow the next state

	// reset stays on until power has been back for the hold time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			board_power_en <= 1'b1;
			system_reset_n <= 1'b1;
		end else begin
			board_power_en <= !(state_d == wdt_resp_pkg::ST_OFF_WAIT ||
				state_d == wdt_resp_pkg::ST_SHUTDOWN);
			system_reset_n <= (state_d == wdt_resp_pkg::ST_IDLE);
		end
	end

endmodule

`default_nettype wire

// ==== tb/super_io_model.sv ====
// behavioural super i/o chip: watchdog flag and monitor alert, both asserted low
`timescale 1ns/1ps
`default_nettype none

module super_io_model (
	input  wire logic pclk,
	input  wire logic wdt_req,
	input  wire logic mon_req,
	output var  logic external_timeout_pin,
	output var  logic external_monitor_alert_pin_n
);
	// push-pull flags; they move just after an edge, like the chip's own flops
	initial begin
		external_timeout_pin = 1'b1;
		external_monitor_alert_pin_n = 1'b1;
		forever begin
			@(posedge pclk);
			external_timeout_pin <= !wdt_req;
			external_monitor_alert_pin_n <= !mon_req;
		end
	end
endmodule

`default_nettype wire

// ==== tb/test_sysmgmt_watchdog_response.sv ====
// self-checking bench for the timeout response controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module test_sysmgmt_watchdog_response;
	localparam int COLD = 20;
	localparam int CYC  = 15;
	localparam int HW   = 5;
	localparam logic [11:0] A_J = wdt_resp_pkg::IDX_JUMPER << 2;
	localparam logic [11:0] A_R = wdt_resp_pkg::IDX_RESPONSE << 2;
	localparam logic [11:0] A_S = wdt_resp_pkg::IDX_IRQ_STATUS << 2;
	localparam logic [11:0] A_M = wdt_resp_pkg::IDX_IRQ_MASK << 2;
	localparam logic [11:0] A_C = wdt_resp_pkg::IDX_CONFIG << 2;
	typedef struct packed {
		logic        w;
		logic        uj;
		logic        sj;
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] exp;
		logic        err;
	} row_t;
	// writes in the table only check the error flag
	row_t rows [13] = '{'{0, 0, 0, A_J, 0, 0, 0}, '{0, 1, 0, A_J, 0, 2, 0}, '{0, 0, 1, A_J, 0, 1, 0},
		'{1, 1, 1, A_J, 32'hFF, 0, 0}, '{0, 1, 1, A_J, 0, 3, 0}, '{1, 0, 0, A_R, 32'hFFFFFFFF, 0, 0},
		'{0, 0, 0, A_R, 0, 32'h33, 0}, '{0, 0, 0, A_M, 0, 0, 0}, '{1, 0, 0, A_M, 32'hFF, 0, 0},
		'{0, 0, 0, A_M, 0, 7, 0}, '{0, 0, 0, A_C, 0, 0, 0}, '{0, 0, 0, 12'h75C, 0, 0, 1},
		'{1, 0, 0, 12'h749, 32'h1, 0, 1}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_v;
	logic        user_jumper_installed, settings_reset_jumper_installed, wdt_req, mon_req;
	logic        external_timeout_pin, external_monitor_alert_pin_n;
	logic        thermal_alarm_out_n, board_power_en, system_reset_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	int          bad_count = 0, n_tests = 0, cyc = 0, p, r;
	int          pe [4] = '{0, COLD, CYC, 0};

	timeout_response #(.COLD_OFF_CYC(COLD), .CYCLE_OFF_CYC(CYC), .HW_RESET_CYC(HW)) u_dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.user_jumper_installed, .settings_reset_jumper_installed, .external_timeout_pin,
		.external_monitor_alert_pin_n, .thermal_alarm_out_n, .board_power_en, .system_reset_n, .irq);
	super_io_model u_sio (.pclk, .wdt_req, .mon_req, .external_timeout_pin, .external_monitor_alert_pin_n);

	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pin held for a fixed window while power and reset low time is counted
	task automatic fire(input logic t);
		p = 0;
		r = 0;
		if (t) wdt_req <= 1'b1;
		else mon_req <= 1'b1;
		repeat (60) begin
			@(posedge pclk);
			p += board_power_en === 1'b0;
			r += system_reset_n === 1'b0;
		end
	endtask
	task automatic release_pins();
		wdt_req <= 1'b0;
		mon_req <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic do_reset();
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, wdt_req, mon_req} = '0;
		{user_jumper_installed, settings_reset_jumper_installed} = '0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		do_reset();
		foreach (rows[i]) begin
			user_jumper_installed <= rows[i].uj;
			settings_reset_jumper_installed <= rows[i].sj;
			repeat (3) @(posedge pclk);
			apb(rows[i].w, rows[i].a, rows[i].d);
			`CHK("pslverr", rows[i].err, err_v)
			if (!rows[i].w) `CHK("prdata", rows[i].exp, rd_v)
		end
		for (int c = 0; c < 4; c++) begin
			apb(1, A_R, 32'(c) << 4);
			fire(1);
			if (c == 0) begin
				apb(0, A_R, 0);
				`CHK("pin state", 32'h80, rd_v)
			end
			release_pins();
			`CHK("power off time", 1'b1, p >= pe[c] && p <= pe[c] + 1)
			`CHK("reset time", 1'b1, c == 0 ? r == 0 : c == 3 ? r >= HW && r <= HW + 2 : r >= HW)
			`CHK("irq", 1'b1, irq)
			apb(0, A_S, 0);
			`CHK("status", c == 0 ? 32'h1 : 32'h5, rd_v)
			apb(1, A_S, 32'h7);
			repeat (2) @(posedge pclk);
			`CHK("irq clear", 1'b0, irq)
		end
		apb(1, A_M, 0);
		apb(1, A_R, 0);
		fire(1);
		release_pins();
		`CHK("irq masked", 1'b0, irq)
		apb(1, A_M, 32'h1);
		repeat (2) @(posedge pclk);
		`CHK("irq unmasked", 1'b1, irq)
		apb(1, A_S, 32'h7);
		repeat (2) @(posedge pclk);
		`CHK("irq cleared", 1'b0, irq)
		for (int m = 1; m < 3; m++) begin
			apb(1, A_R, 32'(m));
			fire(0);
			`CHK("thermal", m != 1, thermal_alarm_out_n)
			if (m == 1) begin
				apb(0, A_R, 0);
				`CHK("monitor pin state", 32'h9, rd_v)
			end
			release_pins();
			`CHK("monitor off time", 1'b1, m == 1 ? p == 0 : p >= COLD && p <= COLD + 1)
		end
		repeat (3) @(posedge pclk);
		`CHK("thermal idle", 1'b1, thermal_alarm_out_n)
		apb(0, A_S, 0);
		`CHK("monitor status", 32'h6, rd_v)
		// shutdown lasts until reset, so each one ends with a mid-run reset
		for (int k = 0; k < 2; k++) begin
			apb(1, A_C, 32'h1);
			apb(1, A_R, k ? 32'h3 : 32'h30);
			fire(k == 0);
			`CHK("shutdown", 1'b1, p >= 55 && r >= 55)
			release_pins();
			do_reset();
			@(posedge pclk);
			`CHK("reset outputs", 4'hD, {board_power_en, system_reset_n, irq, thermal_alarm_out_n})
			apb(0, A_R, 0);
			`CHK("selects after reset", 32'h0, rd_v)
		end
		report_and_stop();
	end
endmodule

`default_nettype wire

// ==== tb/timeout_response_sva.sv ====
// port-level assertions for the timeout response controller
`timescale 1ns/1ps
`default_nettype none

module timeout_response_sva #(
	parameter int unsigned COLD_OFF_CYC  = 20,
	parameter int unsigned CYCLE_OFF_CYC = 15,
	parameter int unsigned HW_RESET_CYC  = 5
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        user_jumper_installed,
	input wire logic        settings_reset_jumper_installed,
	input wire logic        external_timeout_pin,
	input wire logic        external_monitor_alert_pin_n,
	input wire logic        thermal_alarm_out_n,
	input wire logic        board_power_en,
	input wire logic        system_reset_n,
	input wire logic        irq
);
	localparam int C_LO = COLD_OFF_CYC - 1;
	localparam int Y_LO = CYCLE_OFF_CYC - 1;
	localparam int H_HI = HW_RESET_CYC + 3;
	localparam logic [11:0] A_J = wdt_resp_pkg::IDX_JUMPER << 2;
	localparam logic [11:0] A_R = wdt_resp_pkg::IDX_RESPONSE << 2;
	localparam logic [11:0] A_C = wdt_resp_pkg::IDX_CONFIG << 2;
	logic [1:0] wsel_q, msel_q;
	logic       cfg_q;
	wire logic  done = psel && penable && pready && !pslverr;
	wire logic  idle = board_power_en && system_reset_n;
	wire logic  tpin = external_timeout_pin;
	wire logic  mpin = external_monitor_alert_pin_n;

	////////////////////////////////////////////////////////////////
	// shadow of the writable selects, so responses can be predicted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wsel_q <= 2'h0;
			msel_q <= 2'h0;
			cfg_q <= 1'b0;
		end else if (done && pwrite && paddr == A_R) begin
			wsel_q <= pwdata[5:4];
			msel_q <= pwdata[1:0];
		end else if (done && pwrite && paddr == A_C) begin
			cfg_q <= pwdata[0];
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_tfell;
		idle && mpin && $fell(tpin);
	endsequence
	sequence s_mfell;
		idle && tpin && $fell(mpin);
	endsequence
	// power held off for the full count, then back within a few cycles
	sequence s_cold;
		(!board_power_en throughout ##C_LO 1'b1) ##[1:3] board_power_en;
	endsequence
	sequence s_cycle;
		(!board_power_en throughout ##Y_LO 1'b1) ##[1:3] board_power_en;
	endsequence

	a_jumper_reserved: assert property (done && !pwrite && paddr == A_J |-> prdata[31:2] == 30'h0)
		else $error("jumper reserved bits not zero");
	a_jumper_state: assert property (done && !pwrite && paddr == A_J
		&& $past(user_jumper_installed, 2) == user_jumper_installed
		&& $past(settings_reset_jumper_installed, 2) == settings_reset_jumper_installed
		|-> prdata[1:0] == {user_jumper_installed, settings_reset_jumper_installed})
		else $error("jumper bits do not follow jumpers");
	a_pin_mirror: assert property (done && !pwrite && paddr == A_R && $past(tpin, 2) == tpin
		|-> prdata[7] == !tpin && prdata[6] == 1'b0) else $error("timeout pin state wrong");
	a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a one cycle answer");
	a_bad_addr: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	a_tmo_none: assert property ((s_tfell and (wsel_q == 2'h0)) |=> idle [*4])
		else $error("code 00 acted");
	a_tmo_cold: assert property ((s_tfell and (wsel_q == 2'h1)) |=> s_cold)
		else $error("cold reset off time wrong");
	a_tmo_cycle: assert property ((s_tfell and (wsel_q == 2'h2)) |=> s_cycle)
		else $error("power cycle off time wrong");
	a_hw_reset: assert property ((s_tfell and (wsel_q == 2'h3 && !cfg_q))
		|=> (board_power_en && !system_reset_n) [*4] ##[1:H_HI] system_reset_n)
		else $error("hardware reset pulse wrong");
	a_mon_cold: assert property ((s_mfell and (msel_q == 2'h2)) |=> s_cold)
		else $error("monitor cold reset wrong");
	a_mon_off: assert property ((s_mfell and (msel_q == 2'h3)) |=> (!board_power_en && !system_reset_n) [*8])
		else $error("monitor power off wrong");
	a_thermal_on: assert property ($past(msel_q) == 2'h1 && $past(msel_q, 2) == 2'h1
		&& !$past(mpin) && !$past(mpin, 2) |-> !thermal_alarm_out_n) else $error("thermal alarm missing");
	a_thermal_off: assert property (($past(msel_q) != 2'h1 && $past(msel_q, 2) != 2'h1)
		|| ($past(mpin) && $past(mpin, 2)) |-> thermal_alarm_out_n) else $error("thermal alarm spurious");
endmodule

bind timeout_response timeout_response_sva #(
	.COLD_OFF_CYC(COLD_OFF_CYC), .CYCLE_OFF_CYC(CYCLE_OFF_CYC), .HW_RESET_CYC(HW_RESET_CYC)
) u_sva (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.user_jumper_installed, .settings_reset_jumper_installed, .external_timeout_pin,
	.external_monitor_alert_pin_n, .thermal_alarm_out_n, .board_power_en, .system_reset_n, .irq
);

`default_nettype wire
